// >>> verilog/tsi_switch_config.sv
`timescale 1ns/100ps
module tsi_switch_config (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // host parallel port
  input wire logic host_req,
  input wire logic host_wr,
  input wire logic [5:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_ack,
  // received bytes bound for the data memory
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [7:0] rx_addr,
  input wire logic [7:0] rx_data,
  // frame timing and drive enable
  input wire logic frame_sync,
  input wire logic bit_stb,
  input wire logic master_drive_pin,
  // serial side
  output logic [tsi_pkg::N_STREAMS-1:0] serial_outputs,
  output logic [tsi_pkg::N_STREAMS-1:0] serial_oe_n,
  output logic external_control_bit
);
  import tsi_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] ctrl_r, ctrl_nxt;
  logic split_access_bit, processor_output_bit;
  logic [1:0] memory_select_field, target;
  logic [2:0] stream_select_field;
  logic is_creg, mem_wr, host_dm_rd;
  logic [7:0] host_mem_addr;
  rsel_e rsel_r, rsel_nxt;
  logic acc_r, acc_nxt, ack_r, ack_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic src_b_we, cw_b_we, dm_b_we;
  logic [7:0] dm_b_addr, src_a_q, src_b_q, dm_a_q, dm_b_q;
  logic [CW_BITS-1:0] cw_a_q, cw_b_q;
  logic [15:0] fifo_out_data;
  logic fifo_out_valid, fifo_out_ready;
  logic [2:0] bit_r, bit_nxt;
  logic [4:0] ch_r, ch_nxt;
  logic boundary;
  fetch_e fst_r, fst_nxt;
  logic [2:0] fstream_r, fstream_nxt;
  logic [4:0] fch_r, fch_nxt;
  logic [7:0] src_addr;
  logic direct;
  logic [N_STREAMS-1:0][7:0] cur_byte_r, cur_byte_nxt, next_byte_r, next_byte_nxt;
  logic [N_STREAMS-1:0][7:0] fet_byte_r, fet_byte_nxt;
  logic [N_STREAMS-1:0] cur_oe_r, cur_oe_nxt, next_oe_r, next_oe_nxt, fet_oe_r, fet_oe_nxt;
  logic [N_STREAMS-1:0] next_cco_r, next_cco_nxt, fet_cco_r, fet_cco_nxt;
  logic [N_STREAMS-1:0] tx_r, tx_nxt, oe_n_r, oe_n_nxt;
  logic ext_r, ext_nxt, cco_sel;

  // ----------------------------------------------------------------
  // host decode
  // ----------------------------------------------------------------
  // field views of the control register
  always_comb begin
    split_access_bit = ctrl_r[CR_SPLIT_BIT];
    processor_output_bit = ctrl_r[CR_PROC_BIT];
    memory_select_field = ctrl_r[CR_MSEL_HI:CR_MSEL_LO];
    stream_select_field = ctrl_r[CR_STREAM_HI:0];
  end

  // target memory and address of a host access
  always_comb begin
    is_creg = ~host_addr[ADDR_MEM_BIT]; // see R16
    host_mem_addr = {stream_select_field, host_addr[ADDR_CHAN_HI:0]}; // see R7 see R16
    if (split_access_bit) begin
      target = host_wr ? MSEL_SRC : MSEL_DATA; // see R1
    end else begin
      target = memory_select_field; // see R2
    end
    mem_wr = host_req & host_wr & ~is_creg;
    src_b_we = mem_wr & (target == MSEL_SRC); // see R5
    cw_b_we = mem_wr & (target == MSEL_CTRL); // see R5
    host_dm_rd = host_req & ~host_wr & ~is_creg & (target == MSEL_DATA);
  end

  // control register, read selector and answer pipeline
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (host_req & host_wr & is_creg) begin
      ctrl_nxt = host_wdata & CR_WMASK; // see R18
    end
    acc_nxt = host_req;
    rsel_nxt = RS_NONE;
    if (host_req & ~host_wr) begin
      if (is_creg) begin
        rsel_nxt = RS_CREG;
      end else begin
        unique case (target) // see R5 see R6
          MSEL_DATA: rsel_nxt = RS_DATA;
          MSEL_SRC: rsel_nxt = RS_SRC;
          MSEL_CTRL: rsel_nxt = RS_CW;
          MSEL_NONE: rsel_nxt = RS_NONE;
        endcase
      end
    end
    ack_nxt = acc_r;
    rdata_nxt = rdata_r;
    if (acc_r) begin
      unique case (rsel_r)
        RS_CREG: rdata_nxt = ctrl_r;
        RS_DATA: rdata_nxt = dm_b_q;
        RS_SRC: rdata_nxt = src_b_q;
        RS_CW: rdata_nxt = {CW_ZERO_HI, cw_b_q}; // see R8
        RS_NONE: rdata_nxt = 8'h00;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_r <= CR_RESET;
      acc_r <= 1'b0;
      rsel_r <= RS_NONE;
      ack_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      ctrl_r <= ctrl_nxt;
      acc_r <= acc_nxt;
      rsel_r <= rsel_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign host_ack = ack_r;
  assign host_rdata = rdata_r;

  // ----------------------------------------------------------------
  // memories and received-byte buffer
  // ----------------------------------------------------------------
  // host data reads take the data memory port; the buffer waits meanwhile
  always_comb begin
    fifo_out_ready = ~host_dm_rd;
    dm_b_we = fifo_out_valid & ~host_dm_rd;
    dm_b_addr = host_dm_rd ? host_mem_addr : fifo_out_data[15:8];
  end

  word_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .sys_clk(sys_clk), .srst(srst),
    .in_valid(rx_valid), .in_ready(rx_ready), .in_data({rx_addr, rx_data}),
    .out_valid(fifo_out_valid), .out_ready(fifo_out_ready), .out_data(fifo_out_data)
  );

  chan_ram #(.WIDTH(CW_BITS), .DEPTH(256)) u_ctrl_mem (
    .sys_clk(sys_clk), .srst(srst),
    .a_addr({fstream_r, fch_r}), .a_rdata(cw_a_q),
    .b_addr(host_mem_addr), .b_we(cw_b_we), .b_wdata(host_wdata[CW_BITS-1:0]),
    .b_rdata(cw_b_q)
  );

  chan_ram #(.WIDTH(8), .DEPTH(256)) u_src_mem (
    .sys_clk(sys_clk), .srst(srst),
    .a_addr({fstream_r, fch_r}), .a_rdata(src_a_q),
    .b_addr(host_mem_addr), .b_we(src_b_we), .b_wdata(host_wdata),
    .b_rdata(src_b_q)
  );

  chan_ram #(.WIDTH(8), .DEPTH(256)) u_data_mem (
    .sys_clk(sys_clk), .srst(srst),
    .a_addr(src_addr), .a_rdata(dm_a_q),
    .b_addr(dm_b_addr), .b_we(dm_b_we), .b_wdata(fifo_out_data[7:0]),
    .b_rdata(dm_b_q)
  );

  // ----------------------------------------------------------------
  // frame counters and per-channel fetch
  // ----------------------------------------------------------------
  // bit and channel position within the frame
  always_comb begin
    bit_nxt = bit_r;
    ch_nxt = ch_r;
    boundary = frame_sync | (bit_stb & (bit_r == LAST_BIT));
    if (frame_sync) begin
      bit_nxt = 3'h0;
      ch_nxt = 5'h00;
    end else if (bit_stb) begin
      bit_nxt = bit_r + 3'h1;
      if (bit_r == LAST_BIT) begin
        ch_nxt = ch_r + 5'h01;
      end
    end
  end

  // fetch of channel two ahead, stream by stream
  always_comb begin
    fst_nxt = fst_r;
    fstream_nxt = fstream_r;
    fch_nxt = fch_r;
    fet_byte_nxt = fet_byte_r;
    fet_oe_nxt = fet_oe_r;
    fet_cco_nxt = fet_cco_r;
    src_addr = {src_a_q[SW_STREAM_HI:SW_STREAM_LO], src_a_q[SW_CHAN_HI:0]}; // see R12 see R13
    direct = cw_a_q[CW_SRC_BIT] | processor_output_bit; // see R9 see R14 see R17
    unique case (fst_r)
      FS_IDLE: ;
      FS_ADDR: fst_nxt = FS_CMV;
      FS_CMV: begin
        fet_oe_nxt[fstream_r] = cw_a_q[CW_OE_BIT];
        fet_cco_nxt[fstream_r] = cw_a_q[CW_CCO_BIT];
        if (direct) begin
          fet_byte_nxt[fstream_r] = src_a_q; // see R3 see R14
          fst_nxt = (fstream_r == LAST_BIT) ? FS_IDLE : FS_ADDR;
          fstream_nxt = fstream_r + 3'h1;
        end else begin
          fst_nxt = FS_DMV; // see R4 see R9
        end
      end
      FS_DMV: begin
        fet_byte_nxt[fstream_r] = dm_a_q;
        fst_nxt = (fstream_r == LAST_BIT) ? FS_IDLE : FS_ADDR;
        fstream_nxt = fstream_r + 3'h1;
      end
    endcase
    if (boundary) begin
      fst_nxt = FS_ADDR;
      fstream_nxt = 3'h0;
      fch_nxt = ch_nxt + FETCH_LEAD;
    end
  end

  // ----------------------------------------------------------------
  // serial outputs
  // ----------------------------------------------------------------
  // pipeline fetch -> next -> current at each channel boundary
  always_comb begin
    cur_byte_nxt = cur_byte_r;
    cur_oe_nxt = cur_oe_r;
    next_byte_nxt = next_byte_r;
    next_oe_nxt = next_oe_r;
    next_cco_nxt = next_cco_r;
    if (boundary) begin
      cur_byte_nxt = next_byte_r;
      cur_oe_nxt = next_oe_r;
      next_byte_nxt = fet_byte_r;
      next_oe_nxt = fet_oe_r;
      next_cco_nxt = fet_cco_r;
    end
    cco_sel = next_cco_r[bit_r]; // see R10
    ext_nxt = cco_sel;
  end

  // per-stream slot bit and driver enable
  for (genvar s = 0; s < N_STREAMS; s++) begin : g_stream
    always_comb begin
      tx_nxt[s] = cur_byte_r[s][LAST_BIT - bit_r];
      oe_n_nxt[s] = ~(master_drive_pin & (processor_output_bit | cur_oe_r[s])); // see R11 see R15 see R17
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bit_r <= 3'h0;
      ch_r <= 5'h00;
      fst_r <= FS_IDLE;
      fstream_r <= 3'h0;
      fch_r <= 5'h00;
      fet_byte_r <= '0;
      fet_oe_r <= '0;
      fet_cco_r <= '0;
      cur_byte_r <= '0;
      cur_oe_r <= '0;
      next_byte_r <= '0;
      next_oe_r <= '0;
      next_cco_r <= '0;
      tx_r <= '0;
      oe_n_r <= '1;
      ext_r <= 1'b0;
    end else begin
      bit_r <= bit_nxt;
      ch_r <= ch_nxt;
      fst_r <= fst_nxt;
      fstream_r <= fstream_nxt;
      fch_r <= fch_nxt;
      fet_byte_r <= fet_byte_nxt;
      fet_oe_r <= fet_oe_nxt;
      fet_cco_r <= fet_cco_nxt;
      cur_byte_r <= cur_byte_nxt;
      cur_oe_r <= cur_oe_nxt;
      next_byte_r <= next_byte_nxt;
      next_oe_r <= next_oe_nxt;
      next_cco_r <= next_cco_nxt;
      tx_r <= tx_nxt;
      oe_n_r <= oe_n_nxt;
      ext_r <= ext_nxt;
    end
  end

  assign serial_outputs = tx_r;
  assign serial_oe_n = oe_n_r;
  assign external_control_bit = ext_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_cw_read;
    host_req && !host_wr && !is_creg && target == MSEL_CTRL;
  endsequence
  sequence s_direct_fetch;
    fst_r == FS_CMV && direct;
  endsequence

  AST_CREG_BIT5_ZERO: assert property (host_req && host_wr && is_creg |=> !ctrl_r[5]) // see R18
    else $error("control register bit 5 stored");
  AST_ACK_TWO: assert property (host_req |-> ##2 host_ack) // see R16
    else $error("host answer not two cycles after request");
  AST_CW_READ_HI: assert property (s_cw_read |-> ##2 host_rdata[7:3] == CW_ZERO_HI) // see R8
    else $error("control word read upper bits not zero");
  AST_SPLIT_WRITE: assert property (split_access_bit && mem_wr |-> src_b_we && !cw_b_we) // see R1
    else $error("split write missed source memory");
  AST_SPLIT_READ: assert property (split_access_bit && host_req && !host_wr && !is_creg
    |=> rsel_r == RS_DATA) // see R1
    else $error("split read missed data memory");
  AST_MSEL_CTRL: assert property (!split_access_bit && memory_select_field == MSEL_CTRL
    && mem_wr |-> cw_b_we && !src_b_we) // see R2
    else $error("memory select ignored on write");
  AST_DRIVE_OFF: assert property (!master_drive_pin |=> serial_oe_n == '1) // see R15
    else $error("output driven while drive pin low");
  AST_PROC_DRIVE: assert property (master_drive_pin && processor_output_bit
    |=> serial_oe_n == '0) // see R17
    else $error("processor mode left a slot floating");
  AST_OE_BIT: assert property (master_drive_pin && !processor_output_bit
    |=> serial_oe_n == ~$past(cur_oe_r)) // see R11
    else $error("slot enable does not follow enable bit");
  AST_CCO_LEAD: assert property (external_control_bit == $past(cco_sel)) // see R10
    else $error("external control bit not from next channel");
  AST_DIRECT_NO_DM: assert property (s_direct_fetch |=> fst_r != FS_DMV) // see R9
    else $error("direct slot fetched data memory");
endmodule // tsi_switch_config

// >>> shared/tsi_pkg.sv
// Functional notes
// (R1) split bit set: host reads hit data memory, host writes hit source memory
// (R2) split bit clear: memory field picks target; stream field picks subsection
// (R3) processor bit set: every output slot carries its source byte unless drive pin low
// (R4) processor bit clear: each channel's control word decides its slot
// (R5) memory field 01 data (read only), 10 source memory, 11 control memory
// (R6) host never writes memory field 00; device treats it as no memory
// (R7) stream field is a binary stream number selecting the reachable subsection
// (R8) control word reads return zero in its upper five bits
// (R9) source-type bit set outputs source byte, clear uses byte as data address
// (R10) external control bit leads its channel by one, stream 0 first
// (R11) drive pin high and processor bit clear: enable bit drives or floats slot
// (R12) source word bits 7..5 give the source stream, bit 7 most significant
// (R13) source word bits 4..0 give the source channel, bit 4 most significant
// (R14) source-type or processor bit set sends the whole source word
// (R15) drive pin low floats every serial output regardless of anything else
// (R16) address line five low hits control register, high picks one of 32 channels
// (R17) processor bit set acts as if source-type and enable bits were set
// (R18) control register bit 5 ignores writes and reads zero
package tsi_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int N_STREAMS = 8;
  localparam int N_CHANS = 32;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] FETCH_LEAD = 5'h02; // fetch runs two channels ahead
  // ----------------------------------------------------------------
  // switch_control layout
  // ----------------------------------------------------------------
  localparam int CR_SPLIT_BIT = 7;
  localparam int CR_PROC_BIT = 6;
  localparam int CR_MSEL_HI = 4;
  localparam int CR_MSEL_LO = 3;
  localparam int CR_STREAM_HI = 2;
  localparam logic [7:0] CR_RESET = 8'h00;
  localparam logic [7:0] CR_WMASK = 8'hDF; // bit 5 has no storage
  localparam logic [1:0] MSEL_NONE = 2'h0;
  localparam logic [1:0] MSEL_DATA = 2'h1;
  localparam logic [1:0] MSEL_SRC = 2'h2;
  localparam logic [1:0] MSEL_CTRL = 2'h3;
  // ----------------------------------------------------------------
  // channel_control_word and channel_source_word layout
  // ----------------------------------------------------------------
  localparam int CW_BITS = 3;
  localparam int CW_SRC_BIT = 2;
  localparam int CW_CCO_BIT = 1;
  localparam int CW_OE_BIT = 0;
  localparam logic [4:0] CW_ZERO_HI = 5'h00;
  localparam int SW_STREAM_HI = 7;
  localparam int SW_STREAM_LO = 5;
  localparam int SW_CHAN_HI = 4;
  // ----------------------------------------------------------------
  // host port, frame bit index and state encodings
  // ----------------------------------------------------------------
  localparam int ADDR_MEM_BIT = 5;
  localparam int ADDR_CHAN_HI = 4;
  localparam logic [2:0] LAST_BIT = 3'h7;
  typedef enum logic [2:0] {RS_NONE, RS_CREG, RS_DATA, RS_SRC, RS_CW} rsel_e;
  typedef enum logic [1:0] {FS_IDLE, FS_ADDR, FS_CMV, FS_DMV} fetch_e;
endpackage

// >>> verilog/chan_ram.sv
`timescale 1ns/100ps
module chan_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256
) (
  // clock
  input wire logic sys_clk,
  input wire logic srst,
  // read-only port
  input wire logic [$clog2(DEPTH)-1:0] a_addr,
  output logic [WIDTH-1:0] a_rdata,
  // read or write port
  input wire logic [$clog2(DEPTH)-1:0] b_addr,
  input wire logic b_we,
  input wire logic [WIDTH-1:0] b_wdata,
  output logic [WIDTH-1:0] b_rdata
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] a_rdata_nxt;
  logic [WIDTH-1:0] b_rdata_nxt;

  // registered reads, old data on a write collision
  always_comb begin
    a_rdata_nxt = mem[a_addr];
    b_rdata_nxt = mem[b_addr];
  end

  // contents hold no reset value
  always_ff @(posedge sys_clk) begin
    if (b_we) begin
      mem[b_addr] <= b_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      a_rdata <= '0;
      b_rdata <= '0;
    end else begin
      a_rdata <= a_rdata_nxt;
      b_rdata <= b_rdata_nxt;
    end
  end
endmodule // chan_ram

// >>> verilog/word_fifo.sv
`timescale 1ns/100ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock
  input wire logic sys_clk,
  input wire logic srst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store_r [DEPTH];
  logic [AW:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic push, pop;

  // full when pointers differ only in the wrap bit
  always_comb begin
    in_ready = (wr_ptr_r ^ rd_ptr_r) != {1'b1, {AW{1'b0}}};
    out_valid = wr_ptr_r != rd_ptr_r;
    out_data = store_r[rd_ptr_r[AW-1:0]];
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    wr_ptr_nxt = wr_ptr_r + (AW+1)'(push);
    rd_ptr_nxt = rd_ptr_r + (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      store_r[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
    end
  end
endmodule // word_fifo

// >>> tb/host_model.sv
`timescale 1ns/100ps
module host_model (
  // clock
  input wire logic sys_clk,
  // request lines
  output logic host_req,
  output logic host_wr,
  output logic [5:0] host_addr,
  output logic [7:0] host_wdata,
  // answer lines
  input wire logic [7:0] host_rdata,
  input wire logic host_ack
);
  // --------------------
  // host processor model
  // --------------------
  // idle bus at time zero
  initial begin
    host_req = 1'b0;
    host_wr = 1'b0;
    host_addr = 6'h00;
    host_wdata = 8'h00;
  end

  // one access; the answer is due exactly two cycles after the request is taken
  task automatic access(input logic wr, input logic [5:0] a, input logic [7:0] d,
                        output logic [7:0] q, output bit ok);
    @(posedge sys_clk);
    host_req <= 1'b1;
    host_wr <= wr;
    host_addr <= a;
    host_wdata <= d;
    @(posedge sys_clk);
    host_req <= 1'b0;
    host_wdata <= ~d; // data lines stop showing the old value
    repeat (2) @(posedge sys_clk);
    ok = (host_ack === 1'b1);
    q = host_rdata;
  endtask

  // back-to-back reads of channel 0, keeping the data memory busy
  task automatic hog(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      host_req <= 1'b1;
      host_wr <= 1'b0;
      host_addr <= 6'h20;
    end
    @(posedge sys_clk);
    host_req <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
endmodule // host_model

// >>> tb/tsi_switch_config_bench.sv
`timescale 1ns/100ps
module tsi_switch_config_bench;
  import tsi_pkg::*;
  // --------------------
  // signals and model
  // --------------------
  logic sys_clk, srst, host_req, host_wr, host_ack, rx_valid, rx_ready;
  logic [5:0] host_addr;
  logic [7:0] host_wdata, host_rdata, rx_addr, rx_data, q, d;
  logic frame_sync, bit_stb, master_drive_pin, external_control_bit;
  logic [N_STREAMS-1:0] serial_outputs, serial_oe_n;
  logic [7:0] src_m [256];
  logic [2:0] ctl_m [256];
  logic [7:0] dat_m [256];
  bit ok, acc;
  int n;
  int failures = 0;
  int tests_run = 0;

  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // device and host
  tsi_switch_config u_tsi_switch_config (
    .sys_clk(sys_clk), .srst(srst), .host_req(host_req), .host_wr(host_wr),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_ack(host_ack), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_addr(rx_addr),
    .rx_data(rx_data), .frame_sync(frame_sync), .bit_stb(bit_stb),
    .master_drive_pin(master_drive_pin), .serial_outputs(serial_outputs),
    .serial_oe_n(serial_oe_n), .external_control_bit(external_control_bit));
  host_model u_host_model (
    .sys_clk(sys_clk), .host_req(host_req), .host_wr(host_wr), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .host_ack(host_ack));

  // --------------------
  // helpers
  // --------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // host access; a missing answer ends the run
  task automatic hacc(input logic wr, input logic [5:0] a, input logic [7:0] v);
    u_host_model.access(wr, a, v, q, ok);
    if (!ok) begin
      failures++;
      wrap_up();
    end
  endtask

  // control value; the memory field is never composed as 00
  function automatic logic [7:0] crv(input logic sp, pr, input logic [1:0] ms, input int s);
    return {sp, pr, 1'b0, ms, s[2:0]};
  endfunction

  // offer one received byte, bounded wait for acceptance
  task automatic rx_push(input logic [7:0] a, v, input int bound, output bit got);
    got = 1'b0;
    rx_valid <= 1'b1;
    rx_addr <= a;
    rx_data <= v;
    for (int i = 0; i < bound && !got; i++) begin
      @(posedge sys_clk);
      got = (rx_ready === 1'b1);
    end
  endtask

  // write every stream of one memory, then read all back
  task automatic prog(input logic [1:0] ms);
    logic [7:0] w;
    int x;
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < N_STREAMS; s++) begin
        hacc(1'b1, 6'h00, crv(1'b0, 1'b0, ms, s));
        for (int c = 0; c < N_CHANS; c++) begin
          x = s * 32 + c;
          w = 8'($urandom);
          if (p == 0) begin
            if (ms == MSEL_SRC) src_m[x] = w;
            if (ms == MSEL_CTRL) ctl_m[x] = w[CW_BITS-1:0];
            hacc(1'b1, {1'b1, c[4:0]}, w);
          end else begin
            hacc(1'b0, {1'b1, c[4:0]}, 8'h00);
            check(q, (ms == MSEL_SRC) ? src_m[x] : (ms == MSEL_CTRL) ?
                  {CW_ZERO_HI, ctl_m[x]} : dat_m[x]);
          end
        end
      end
    end
  endtask

  // one frame of 256 bit times, 24 cycles each, checked late in each bit
  task automatic frame(input logic pr);
    logic [7:0] b;
    logic [2:0] w;
    logic e;
    int c;
    int k;
    frame_sync <= 1'b1;
    @(posedge sys_clk);
    frame_sync <= 1'b0;
    for (int i = 0; i < 256; i++) begin
      repeat (23) @(posedge sys_clk);
      c = i / 8;
      k = i % 8;
      for (int s = 0; s < N_STREAMS && c > 1; s++) begin
        w = ctl_m[s*32+c];
        b = (w[CW_SRC_BIT] | pr) ? src_m[s*32+c] : dat_m[src_m[s*32+c]];
        e = ~(master_drive_pin & (pr | w[CW_OE_BIT]));
        check(serial_oe_n[s], e);
        if (!e) check(serial_outputs[s], b[7-k]);
      end
      if (c > 1 && c < 31) check(external_control_bit, ctl_m[k*32+c+1][CW_CCO_BIT]);
      bit_stb <= 1'b1;
      @(posedge sys_clk);
      bit_stb <= 1'b0;
    end
  endtask

  // --------------------
  // main sequence
  // --------------------
  initial begin
    srst = 1'b1;
    rx_valid = 1'b0;
    rx_addr = 8'h00;
    rx_data = 8'h00;
    frame_sync = 1'b0;
    bit_stb = 1'b0;
    master_drive_pin = 1'b0;
    void'($urandom(32'h5C62));
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    check(serial_oe_n, {N_STREAMS{1'b1}});
    hacc(1'b0, 6'h00, 8'h00);
    check(q, CR_RESET);
    hacc(1'b1, 6'h1F, 8'hFF);
    hacc(1'b0, 6'h0A, 8'h00);
    check(q, 8'hDF);
    $display("test control done");
    for (int i = 0; i < 256; i++) begin
      d = 8'($urandom);
      rx_push(8'(i), d, 20, acc);
      check(acc, 1'b1);
      if (!acc) wrap_up();
      dat_m[i] = d;
    end
    rx_valid <= 1'b0;
    // fill the buffer while host reads keep the data memory busy; only a full buffer fits
    hacc(1'b1, 6'h00, crv(1'b0, 1'b0, MSEL_DATA, 0));
    n = 0;
    fork
      u_host_model.hog(40);
      begin
        repeat (3) @(posedge sys_clk);
        for (int i = 0; i < 20; i++) begin
          d = 8'($urandom);
          rx_push(8'hE0 + 8'(i), d, 60, acc);
          check(acc, 1'b1);
          if (!acc) wrap_up();
          if (host_req === 1'b1) n++; // taken while the host still held the data memory
          dat_m[224+i] = d;
        end
        rx_valid <= 1'b0;
      end
    join
    repeat (20) @(posedge sys_clk);
    check(n, FIFO_DEPTH);
    prog(MSEL_DATA);
    $display("test data done");
    prog(MSEL_SRC);
    prog(MSEL_CTRL);
    hacc(1'b1, 6'h00, crv(1'b1, 1'b0, MSEL_CTRL, 3));
    d = 8'($urandom);
    hacc(1'b1, 6'h25, d);
    src_m[101] = d;
    hacc(1'b0, 6'h25, 8'h00);
    check(q, dat_m[101]);
    hacc(1'b1, 6'h00, crv(1'b0, 1'b0, MSEL_SRC, 3));
    hacc(1'b0, 6'h25, 8'h00);
    check(q, src_m[101]);
    $display("test memories done");
    master_drive_pin <= 1'b1;
    hacc(1'b1, 6'h00, crv(1'b0, 1'b1, MSEL_SRC, 0));
    frame(1'b1);
    hacc(1'b1, 6'h00, crv(1'b0, 1'b0, MSEL_SRC, 0));
    frame(1'b0);
    master_drive_pin <= 1'b0;
    frame(1'b0);
    $display("test serial done");
    wrap_up();
  end
endmodule // tsi_switch_config_bench
